// ---- core/clkss_defs.svh ----
`ifndef CLKSS_DEFS_SVH
`define CLKSS_DEFS_SVH

// Register offsets on the 4-bit register address
`define CLKSS_OFS_CTRL 4'h0
`define CLKSS_OFS_CTRL2 4'h1
`define CLKSS_OFS_TUNE 4'h2

// Field positions, control register
`define CLKSS_IDLE_BIT 7
`define CLKSS_INTERNAL_FREQ_SELECT_HI 6
`define CLKSS_INTERNAL_FREQ_SELECT_LO 4
`define CLKSS_PRIMARY_TIMEOUT_FLAG_BIT 3
`define CLKSS_SCS_HI 1
`define CLKSS_SCS_LO 0

// Field positions, second control and tuning registers
`define CLKSS_SOSC_BIT 6
`define CLKSS_SECEN_BIT 0
`define CLKSS_LOW_FREQ_SOURCE_CHOICE_BIT 7

// Source select codes; both codes 2 and 3 pick the internal clock
`define CLKSS_SCS_PRIM 2'h0
`define CLKSS_SCS_SEC 2'h1
`define CLKSS_SCS_RST 2'h0

// Internal frequency select: 7 = 8 MHz, 6 = 4 MHz ... 1 = 125 kHz, 0 = 31 kHz
`define CLKSS_INTERNAL_FREQ_SELECT_RST 3'h6
`define CLKSS_INTERNAL_FREQ_SELECT_LOW 3'h0
`define CLKSS_INTERNAL_FREQ_SELECT_MAX 3'h7
`define CLKSS_DIV_LOW_LOG2 8

// Timing in edges of the clocks concerned
`define CLKSS_OST_EDGES 1024
`define CLKSS_SWITCH_EDGES 4

`endif

// ---- core/clkss_pkg.sv ----
package clkss_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } clkss_bus_s;

   typedef enum logic [0:0] {
      CLKSS_RUN,
      CLKSS_SWITCH
   } clkss_state_e;

endpackage

// ---- core/clkss_edge.sv ----
`timescale 1ns/1ns
module clkss_edge
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Raw oscillator level
   input wire logic i_level,
   // One-cycle pulse on each rising edge
   output logic o_rise
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         o_rise <= 1'b0;
      end
      else
      begin
         meta_reg <= i_level;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         o_rise <= sync_reg & ~last_reg;
      end
   end
endmodule // clkss_edge

// ---- core/clkss_postscale.sv ----
`timescale 1ns/1ns
`include "clkss_defs.svh"
module clkss_postscale
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Source edges
   input wire logic i_fast_rise,
   input wire logic i_lprc_rise,
   // Selection
   input wire logic [2:0] i_freq_sel,
   input wire logic i_low_src,
   // Postscaled internal clock edge
   output logic o_tick
);
   logic [7:0] div_reg;
   logic hit;

   // Mask of low counter bits that must be all ones for a divide by 2^k
   function automatic logic [7:0] div_mask(input logic [2:0] sel);
      logic [3:0] k;
      k = (sel == `CLKSS_INTERNAL_FREQ_SELECT_LOW) ? 4'(`CLKSS_DIV_LOW_LOG2) : 4'(`CLKSS_INTERNAL_FREQ_SELECT_MAX - sel);
      div_mask = 8'((9'h001 << k) - 9'h001);
   endfunction

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         div_reg <= 8'h00;
      else if (i_fast_rise)
         div_reg <= div_reg + 8'h01;
   end

   // Selection acts on the next edge, no resynchronisation
   assign hit = i_fast_rise && ((div_reg & div_mask(i_freq_sel)) == div_mask(i_freq_sel));

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_tick <= 1'b0;
      else if (i_freq_sel == `CLKSS_INTERNAL_FREQ_SELECT_LOW && !i_low_src)
         o_tick <= i_lprc_rise;
      else
         o_tick <= hit;
   end

   low_src_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_freq_sel == `CLKSS_INTERNAL_FREQ_SELECT_LOW && !i_low_src) |=> o_tick == $past(i_lprc_rise))
      else $error("low internal source does not follow the low-power rc");
endmodule // clkss_postscale

// ---- core/clkss_top.sv ----
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "clkss_defs.svh"
module clkss_top
#(
   parameter int OST_EDGES = `CLKSS_OST_EDGES,
   parameter int SWITCH_EDGES = `CLKSS_SWITCH_EDGES
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Register port
   input wire clkss_pkg::clkss_bus_s i_bus,
   output logic [7:0] o_rdata,
   // Oscillator inputs
   input wire logic i_prim_osc,
   input wire logic i_sec_osc,
   input wire logic i_lprc_osc,
   input wire logic i_fast_osc,
   // Core power control
   input wire logic i_sleep_exec,
   input wire logic i_wake,
   // Clock outputs and mode
   output logic o_sys_tick,
   output logic o_wdt_tick,
   output logic o_sec_osc_en,
   output logic o_sleep_mode,
   output logic o_idle_mode
);
   import clkss_pkg::*;

   logic prim_rise;
   logic sec_rise;
   logic lprc_rise;
   logic fast_rise;
   logic int_tick;
   logic [1:0] scs_reg;
   logic [2:0] internal_freq_select_reg;
   logic idle_en_reg;
   logic low_freq_source_choice_reg;
   logic sec_keep_reg;
   logic [1:0] cur_reg;
   clkss_state_e state_reg;
   logic [15:0] sw_cnt_reg;
   logic [15:0] ost_cnt_reg;
   logic ost_done_reg;
   logic primary_timeout_flag_reg;
   logic sosc_reg;
   logic sel_tick;
   logic new_tick;
   logic wr_ctrl;
   logic wr_ctrl2;
   logic wr_tune;
   logic asleep;

   // Tick of whichever source a select code names
   function automatic logic src_tick(input logic [1:0] sel, input logic p, input logic s,
                                     input logic i);
      if (sel == `CLKSS_SCS_PRIM)
         src_tick = p;
      else if (sel == `CLKSS_SCS_SEC)
         src_tick = s;
      else
         src_tick = i;
   endfunction

   clkss_edge u_prim_edge
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_prim_osc),
      .o_rise(prim_rise)
   );

   clkss_edge u_sec_edge
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_sec_osc),
      .o_rise(sec_rise)
   );

   clkss_edge u_lprc_edge
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_lprc_osc),
      .o_rise(lprc_rise)
   );

   clkss_edge u_fast_edge
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_fast_osc),
      .o_rise(fast_rise)
   );

   clkss_postscale u_post
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_fast_rise(fast_rise),
      .i_lprc_rise(lprc_rise),
      .i_freq_sel(internal_freq_select_reg),
      .i_low_src(low_freq_source_choice_reg),
      .o_tick(int_tick)
   );

   assign wr_ctrl = i_bus.wr && i_bus.addr == `CLKSS_OFS_CTRL;
   assign wr_ctrl2 = i_bus.wr && i_bus.addr == `CLKSS_OFS_CTRL2;
   assign wr_tune = i_bus.wr && i_bus.addr == `CLKSS_OFS_TUNE;
   assign sel_tick = src_tick(cur_reg, prim_rise, sec_rise, int_tick);
   assign new_tick = src_tick(scs_reg, prim_rise, sec_rise, int_tick);
   assign asleep = o_sleep_mode || o_idle_mode;

   // Control fields
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         scs_reg <= `CLKSS_SCS_RST;
      else if (wr_ctrl)
         scs_reg <= i_bus.wdata[`CLKSS_SCS_HI:`CLKSS_SCS_LO];
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         internal_freq_select_reg <= `CLKSS_INTERNAL_FREQ_SELECT_RST;
      else if (wr_ctrl)
         internal_freq_select_reg <= i_bus.wdata[`CLKSS_INTERNAL_FREQ_SELECT_HI:`CLKSS_INTERNAL_FREQ_SELECT_LO];
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         idle_en_reg <= 1'b0;
      else if (wr_ctrl)
         idle_en_reg <= i_bus.wdata[`CLKSS_IDLE_BIT];
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         low_freq_source_choice_reg <= 1'b0;
      else if (wr_tune)
         low_freq_source_choice_reg <= i_bus.wdata[`CLKSS_LOW_FREQ_SOURCE_CHOICE_BIT];
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         sec_keep_reg <= 1'b0;
      else if (wr_ctrl2)
         sec_keep_reg <= i_bus.wdata[`CLKSS_SECEN_BIT];
   end

   // Source switch: the system tick stays silent until the new source has
   // shown SWITCH_EDGES edges, then the output moves over with no runt tick
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg <= CLKSS_RUN;
         cur_reg <= `CLKSS_SCS_RST;
         sw_cnt_reg <= 16'h0000;
      end
      else
      begin
         case (state_reg)
            CLKSS_RUN:
            begin
               sw_cnt_reg <= 16'h0000;
               if (scs_reg != cur_reg)
                  state_reg <= CLKSS_SWITCH;
            end
            CLKSS_SWITCH:
            begin
               // A further write restarts the wait on the newest choice
               if (wr_ctrl)
                  sw_cnt_reg <= 16'h0000;
               else if (scs_reg == cur_reg)
                  state_reg <= CLKSS_RUN;
               else if (new_tick && sw_cnt_reg == 16'(SWITCH_EDGES - 1))
               begin
                  cur_reg <= scs_reg;
                  state_reg <= CLKSS_RUN;
               end
               else if (new_tick)
                  sw_cnt_reg <= sw_cnt_reg + 16'h0001;
            end
            default:
               state_reg <= CLKSS_RUN;
         endcase
      end
   end

   // System clock tick, silent while switching or in full sleep
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_sys_tick <= 1'b0;
      else
         o_sys_tick <= state_reg == CLKSS_RUN && !o_sleep_mode && sel_tick;
   end

   // Watchdog and monitor timebase never follow the source choice
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_wdt_tick <= 1'b0;
      else
         o_wdt_tick <= lprc_rise;
   end

   // Start-up timer counts primary edges once after reset
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ost_cnt_reg <= 16'h0000;
         ost_done_reg <= 1'b0;
      end
      else if (prim_rise && !ost_done_reg)
      begin
         ost_cnt_reg <= ost_cnt_reg + 16'h0001;
         if (ost_cnt_reg == 16'(OST_EDGES - 1))
            ost_done_reg <= 1'b1;
      end
   end

   // Status flags derive from one active source, so at most one is set;
   // both clear means the internal clock runs, a switch is under way, or the start-up timer has not expired on primary
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         primary_timeout_flag_reg <= 1'b0;
         sosc_reg <= 1'b0;
      end
      else
      begin
         primary_timeout_flag_reg <= ost_done_reg && state_reg == CLKSS_RUN
                     && cur_reg == `CLKSS_SCS_PRIM;
         sosc_reg <= state_reg == CLKSS_RUN && cur_reg == `CLKSS_SCS_SEC;
      end
   end

   // Secondary oscillator may be kept alive through power-managed modes
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_sec_osc_en <= 1'b0;
      else
         o_sec_osc_en <= sec_keep_reg || scs_reg == `CLKSS_SCS_SEC
                         || cur_reg == `CLKSS_SCS_SEC;
   end

   // Sleep instruction: idle enable chooses the mode
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_sleep_mode <= 1'b0;
         o_idle_mode <= 1'b0;
      end
      else if (asleep && i_wake)
      begin
         o_sleep_mode <= 1'b0;
         o_idle_mode <= 1'b0;
      end
      else if (!asleep && i_sleep_exec)
      begin
         o_sleep_mode <= !idle_en_reg;
         o_idle_mode <= idle_en_reg;
      end
   end

   // Read data, one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_bus.rd)
      begin
         o_rdata <= 8'h00;
         case (i_bus.addr)
            `CLKSS_OFS_CTRL:
            begin
               o_rdata[`CLKSS_IDLE_BIT] <= idle_en_reg;
               o_rdata[`CLKSS_INTERNAL_FREQ_SELECT_HI:`CLKSS_INTERNAL_FREQ_SELECT_LO] <= internal_freq_select_reg;
               o_rdata[`CLKSS_PRIMARY_TIMEOUT_FLAG_BIT] <= primary_timeout_flag_reg;
               o_rdata[`CLKSS_SCS_HI:`CLKSS_SCS_LO] <= scs_reg;
            end
            `CLKSS_OFS_CTRL2:
            begin
               o_rdata[`CLKSS_SOSC_BIT] <= sosc_reg;
               o_rdata[`CLKSS_SECEN_BIT] <= sec_keep_reg;
            end
            `CLKSS_OFS_TUNE:
               o_rdata[`CLKSS_LOW_FREQ_SOURCE_CHOICE_BIT] <= low_freq_source_choice_reg;
            default:
               o_rdata <= 8'h00;
         endcase
      end
   end

   sel_tick_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_sys_tick |-> $past(sel_tick) && $past(state_reg) == CLKSS_RUN)
      else $error("system tick without a tick of the active source");
   switch_start_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_reg == CLKSS_RUN && scs_reg != cur_reg) |=> state_reg == CLKSS_SWITCH)
      else $error("select change did not start a switch");
   scs_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $past(i_rst) |-> scs_reg == `CLKSS_SCS_RST && cur_reg == `CLKSS_SCS_RST)
      else $error("source select not cleared by reset");
   int_now_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_reg == CLKSS_RUN && cur_reg[1] && int_tick && !o_sleep_mode) |=> o_sys_tick)
      else $error("internal tick did not reach the system clock");
   internal_freq_select_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $past(i_rst) |-> internal_freq_select_reg == `CLKSS_INTERNAL_FREQ_SELECT_RST)
      else $error("frequency select not restored by reset");
   wdt_src_a: assert property (@(posedge i_clock) disable iff (i_rst)
      lprc_rise |=> o_wdt_tick)
      else $error("watchdog tick lost");
   primary_timeout_flag_cause_a: assert property (@(posedge i_clock) disable iff (i_rst)
      primary_timeout_flag_reg |-> $past(ost_done_reg) && $past(cur_reg) == `CLKSS_SCS_PRIM)
      else $error("timeout flag without expired timer on primary");
   sosc_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_reg == CLKSS_RUN && cur_reg == `CLKSS_SCS_SEC) |=> sosc_reg)
      else $error("secondary running flag not set");
   flags_excl_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !(primary_timeout_flag_reg && sosc_reg))
      else $error("both status flags set");
   sleep_pick_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (!asleep && i_sleep_exec && !i_wake) |=> o_idle_mode == $past(idle_en_reg)
      && o_sleep_mode == !$past(idle_en_reg))
      else $error("sleep mode does not follow idle enable");
   sec_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
      sec_keep_reg |=> o_sec_osc_en)
      else $error("secondary oscillator dropped");
   switch_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
      state_reg == CLKSS_SWITCH |=> !o_sys_tick)
      else $error("tick while switching sources");

   switch_sec_c: cover property (@(posedge i_clock) disable iff (i_rst)
      state_reg == CLKSS_SWITCH ##1 state_reg == CLKSS_RUN && cur_reg == `CLKSS_SCS_SEC);
   primary_timeout_flag_set_c: cover property (@(posedge i_clock) disable iff (i_rst) $rose(primary_timeout_flag_reg));
   idle_c: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_idle_mode));
   int_run_c: cover property (@(posedge i_clock) disable iff (i_rst)
      cur_reg[1] && state_reg == CLKSS_RUN && o_sys_tick);
endmodule // clkss_top

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   import clkss_pkg::*;
   logic i_clock;
   logic i_rst;
   logic i_prim_osc = 1'b0;
   logic i_sec_osc = 1'b0;
   logic i_lprc_osc = 1'b0;
   logic i_fast_osc = 1'b0;
   logic i_sleep_exec;
   logic i_wake;
   clkss_bus_s bus;
   logic [7:0] o_rdata;
   logic o_sys_tick;
   logic o_wdt_tick;
   logic o_sec_osc_en;
   logic o_sleep_mode;
   logic o_idle_mode;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   int errors = 0;
   int cmp_count = 0;
   int sys_cnt = 0;
   int wdt_cnt = 0;
   int s_n;
   int w_n;
   int seed;

   clkss_top #(.OST_EDGES(8), .SWITCH_EDGES(2)) dut
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_bus(bus),
      .o_rdata(o_rdata),
      .i_prim_osc(i_prim_osc),
      .i_sec_osc(i_sec_osc),
      .i_lprc_osc(i_lprc_osc),
      .i_fast_osc(i_fast_osc),
      .i_sleep_exec(i_sleep_exec),
      .i_wake(i_wake),
      .o_sys_tick(o_sys_tick),
      .o_wdt_tick(o_wdt_tick),
      .o_sec_osc_en(o_sec_osc_en),
      .o_sleep_mode(o_sleep_mode),
      .o_idle_mode(o_idle_mode)
   );
   initial
   begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   // Oscillators toggle on falling clock edges, clear of the sampling edge
   always #24 i_prim_osc = ~i_prim_osc;
   always #32 i_sec_osc = ~i_sec_osc;
   always #80 i_lprc_osc = ~i_lprc_osc;
   always #16 i_fast_osc = ~i_fast_osc;

   always @(posedge i_clock)
   begin
      rd_seen <= bus.rd;
      if (o_sys_tick === 1'b1)
         sys_cnt <= sys_cnt + 1;
      if (o_wdt_tick === 1'b1)
         wdt_cnt <= wdt_cnt + 1;
   end
   // Read data is looked at mid-cycle, once the launching edge has settled
   always @(negedge i_clock)
   begin
      if (rd_seen === 1'b1)
         check_byte(o_rdata, exp_q.pop_front());
   end
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_cnt(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // One gap cycle between requests so no signal is assigned twice per step
   task automatic bus_op(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge i_clock);
      bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge i_clock);
      bus <= '0;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      bus_op(a, d, 1'b1);
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      bus_op(a, 8'h00, 1'b0);
   endtask
   task automatic measure(input int w);
      int s0 = sys_cnt;
      int w0 = wdt_cnt;
      repeat (w) @(posedge i_clock);
      s_n = sys_cnt - s0;
      w_n = wdt_cnt - w0;
   endtask
   task automatic run_src(input logic [7:0] ctrl, input int w);
      wr_reg(4'h0, ctrl);
      repeat (100) @(posedge i_clock);
      measure(w);
   endtask
   task automatic pulse(input logic slp);
      @(posedge i_clock);
      if (slp)
         i_sleep_exec <= 1'b1;
      else
         i_wake <= 1'b1;
      @(posedge i_clock);
      i_sleep_exec <= 1'b0;
      i_wake <= 1'b0;
      repeat (3) @(posedge i_clock);
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #400000;
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
   end

   initial
   begin
      logic [3:0] ua;
      seed = 67915;
      i_rst = 1'b1;
      bus = '0;
      i_sleep_exec = 1'b0;
      i_wake = 1'b0;
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      rd_reg(4'h0, 8'h60);
      rd_reg(4'h1, 8'h00);
      rd_reg(4'h2, 8'h00);
      rd_reg(4'hF, 8'h00);
      repeat (150) @(posedge i_clock);
      rd_reg(4'h0, 8'h68);
      measure(480);
      check_cnt(s_n, 79, 81);
      check_cnt(w_n, 23, 25);
      ua = 4'h3 + 4'(($random(seed) & 32'h7FFFFFFF) % 13);
      wr_reg(ua, 8'($random(seed)));
      rd_reg(4'h0, 8'h68);
      rd_reg(4'h2, 8'h00);
      $display("test reset_and_primary done");
      wr_reg(4'h0, 8'h61);
      wr_reg(4'h1, 8'h01);
      repeat (80) @(posedge i_clock);
      rd_reg(4'h0, 8'h61);
      rd_reg(4'h1, 8'h41);
      measure(512);
      check_cnt(s_n, 63, 65);
      check_bit(o_sec_osc_en, 1'b1);
      $display("test secondary done");
      pulse(1'b1);
      check_bit(o_sleep_mode, 1'b1);
      check_bit(o_idle_mode, 1'b0);
      measure(200);
      check_cnt(s_n, 0, 0);
      check_bit(o_sec_osc_en, 1'b1);
      pulse(1'b0);
      check_bit(o_sleep_mode, 1'b0);
      wr_reg(4'h0, 8'hE1);
      pulse(1'b1);
      check_bit(o_idle_mode, 1'b1);
      check_bit(o_sleep_mode, 1'b0);
      measure(200);
      check_cnt(s_n, 24, 26);
      pulse(1'b0);
      check_bit(o_idle_mode, 1'b0);
      $display("test sleep_idle done");
      // Code 3 held: only the frequency moves, so no switch stalls the count
      for (int k = 7; k >= 1; k--)
      begin
         run_src({1'b0, 3'(k), 4'h3}, 1024);
         check_cnt(s_n, (256 >> (7 - k)) - 1, (256 >> (7 - k)) + 1);
      end
      rd_reg(4'h0, 8'h13);
      rd_reg(4'h1, 8'h01);
      run_src(8'h02, 1024);
      check_cnt(s_n, 50, 53);
      wr_reg(4'h2, 8'h80);
      rd_reg(4'h2, 8'h80);
      run_src(8'h02, 4096);
      check_cnt(s_n, 3, 5);
      check_cnt(w_n, 203, 206);
      $display("test internal done");
      wr_reg(4'h0, 8'h31);
      @(posedge i_clock);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd_reg(4'h0, 8'h60);
      rd_reg(4'h2, 8'h00);
      repeat (5) @(posedge i_clock);
      check_bit(o_sec_osc_en, 1'b0);
      $display("test mid_reset done");
      finish_test();
   end
endmodule // tb_top
